//--- include/ptp_time_pkg.sv
// Package with the register map, reset values and carrier types of the system time counter.
package ptp_time_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_EVENT = 8'h02;
  localparam logic [7:0] OFS_ADDEND_LO = 8'h04;
  localparam logic [7:0] OFS_ADDEND_HI = 8'h06;
  localparam logic [7:0] OFS_FRAC_ACCUMULATOR_LOW = 8'h08;
  localparam logic [7:0] OFS_FRAC_ACCUMULATOR_HIGH = 8'h0a;
  localparam logic [7:0] OFS_TIME_W0 = 8'h0c;
  localparam logic [7:0] OFS_TIME_W1 = 8'h0e;
  localparam logic [7:0] OFS_TIME_W2 = 8'h10;
  localparam logic [7:0] OFS_TIME_W3 = 8'h12;
  localparam logic [7:0] OFS_ALARM_W0 = 8'h14;
  localparam logic [7:0] OFS_ALARM_W1 = 8'h16;
  localparam logic [7:0] OFS_ALARM_W2 = 8'h18;
  localparam logic [7:0] OFS_ALARM_W3 = 8'h1a;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int CTRL_IRQ_MASK_BIT = 0;
  localparam int CTRL_COMPARE_EN_BIT = 4;
  localparam int EVENT_PENDING_BIT = 0;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [31:0] RST_ADDEND = 32'h0000_0000;
  localparam logic [31:0] RST_ACCUM = 32'h0000_0000;
  localparam logic [63:0] RST_TIME = 64'h0000_0000_0000_0000;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  // Load request toward the fractional accumulator.
  typedef struct packed {
    logic load;
    logic [31:0] value;
  } accum_load_t;

  // Software bits of the control register that this block implements.
  typedef struct packed {
    logic compare_enable;
    logic irq_mask;
  } alarm_ctrl_t;

endpackage

//--- rtl/frac_phase_accumulator.sv
// Fractional phase accumulator that turns the addend into time-advance pulses.
`timescale 1ns/1ps
`default_nettype none

module frac_phase_accumulator (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [31:0] addend,
  input wire ptp_time_pkg::accum_load_t load_req,
  output logic [31:0] accum,
  output logic overflow
);

  // ****************************************************************
  // Sum with carry
  // ****************************************************************
  logic [32:0] next_sum;

  // Bit 32 of the 33-bit sum, the carry out of the 32-bit add, is the rollover.
  assign next_sum = {1'b0, accum} + {1'b0, addend};

  // A load replaces the sum for that cycle, so a load never ticks time itself.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      accum <= ptp_time_pkg::RST_ACCUM;
    end else if (load_req.load) begin
      accum <= load_req.value;
    end else begin
      accum <= next_sum[31:0];
    end
  end

  // One registered pulse per wrap; a wrap can happen at most once per cycle.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      overflow <= 1'b0;
    end else begin
      overflow <= next_sum[32] & ~load_req.load;
    end
  end

endmodule // frac_phase_accumulator

`default_nettype wire

//--- rtl/ptp_system_time_counter.sv
// System time counter with addend, accumulator, alarm compare and 16-bit register port.
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module ptp_system_time_counter (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic alarm_irq,
  output logic [63:0] local_time,
  output logic time_tick
);

  // ****************************************************************
  // Address decode
  // ****************************************************************
  // One helper decides a strobe hit for every register, read or write.
  function automatic logic hit(input logic strobe, input logic [7:0] addr,
                               input logic [7:0] offset);
    hit = strobe && (addr == offset);
  endfunction

  logic wr_control;
  logic wr_event;
  logic wr_addend_lo;
  logic wr_addend_hi;
  logic wr_frac_accumulator_low;
  logic wr_frac_accumulator_high;
  logic wr_time_w3;
  logic rd_frac_accumulator_low;
  logic rd_time_w0;

  assign wr_control = hit(reg_wr, reg_addr, ptp_time_pkg::OFS_CONTROL);
  assign wr_event = hit(reg_wr, reg_addr, ptp_time_pkg::OFS_EVENT);
  assign wr_addend_lo = hit(reg_wr, reg_addr, ptp_time_pkg::OFS_ADDEND_LO);
  assign wr_addend_hi = hit(reg_wr, reg_addr, ptp_time_pkg::OFS_ADDEND_HI);
  assign wr_frac_accumulator_low = hit(reg_wr, reg_addr, ptp_time_pkg::OFS_FRAC_ACCUMULATOR_LOW);
  assign wr_frac_accumulator_high = hit(reg_wr, reg_addr, ptp_time_pkg::OFS_FRAC_ACCUMULATOR_HIGH);
  assign wr_time_w3 = hit(reg_wr, reg_addr, ptp_time_pkg::OFS_TIME_W3);
  assign rd_frac_accumulator_low = hit(reg_rd, reg_addr, ptp_time_pkg::OFS_FRAC_ACCUMULATOR_LOW);
  assign rd_time_w0 = hit(reg_rd, reg_addr, ptp_time_pkg::OFS_TIME_W0);

  // ****************************************************************
  // Addend
  // ****************************************************************
  logic [15:0] addend_stage;
  logic [31:0] addend;

  // The low half waits in a stage so the accumulator never sees half a value.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      addend_stage <= ptp_time_pkg::RST_WORD;
    end else if (wr_addend_lo) begin
      addend_stage <= reg_wdata;
    end
  end

  // Zero after reset keeps time frozen until software chooses a rate.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      addend <= ptp_time_pkg::RST_ADDEND;
    end else if (wr_addend_hi) begin
      addend <= {reg_wdata, addend_stage};
    end
  end

  // ****************************************************************
  // Fractional accumulator
  // ****************************************************************
  logic [15:0] accum_stage;
  logic [15:0] accum_hold;
  logic [31:0] accum;
  ptp_time_pkg::accum_load_t accum_load;

  // Low half is staged; the high-half write loads the full word.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      accum_stage <= ptp_time_pkg::RST_WORD;
    end else if (wr_frac_accumulator_low) begin
      accum_stage <= reg_wdata;
    end
  end

  assign accum_load.load = wr_frac_accumulator_high;
  assign accum_load.value = {reg_wdata, accum_stage};

  // The accumulator keeps moving, so a low read freezes the high half for the next read.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      accum_hold <= ptp_time_pkg::RST_WORD;
    end else if (rd_frac_accumulator_low) begin
      accum_hold <= accum[31:16];
    end
  end

  frac_phase_accumulator u_accum (
    .clock(clock),
    .sys_rst(sys_rst),
    .addend(addend),
    .load_req(accum_load),
    .accum(accum),
    .overflow(time_tick)
  );

  // ****************************************************************
  // System time counter
  // ****************************************************************
  logic [47:0] time_stage;
  logic [47:0] time_hold;

  // Words 0 to 2 are staged by a loop over the three lower offsets.
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_time_stage
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          time_stage[gi*16 +: 16] <= ptp_time_pkg::RST_WORD;
        end else if (hit(reg_wr, reg_addr, ptp_time_pkg::OFS_TIME_W0 + 8'(2 * gi))) begin
          time_stage[gi*16 +: 16] <= reg_wdata;
        end
      end
    end
  endgenerate

  // A software load beats a tick in the same cycle; that tick is lost by design.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      local_time <= ptp_time_pkg::RST_TIME;
    end else if (wr_time_w3) begin
      local_time <= {reg_wdata, time_stage};
    end else if (time_tick) begin
      local_time <= local_time + 64'h0000_0000_0000_0001;
    end
  end

  // A word 0 read takes a coherent snapshot of the upper three words.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      time_hold <= 48'h0000_0000_0000;
    end else if (rd_time_w0) begin
      time_hold <= local_time[63:16];
    end
  end

  // ****************************************************************
  // Alarm time and compare
  // ****************************************************************
  logic [63:0] alarm_time;
  ptp_time_pkg::alarm_ctrl_t ctrl;
  logic alarm_match;
  logic alarm_one_pending;

  // Each alarm word is written straight into the compare value, in any order.
  generate
    for (gi = 0; gi < 4; gi++) begin : g_alarm_word
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          alarm_time[gi*16 +: 16] <= ptp_time_pkg::RST_WORD;
        end else if (hit(reg_wr, reg_addr, ptp_time_pkg::OFS_ALARM_W0 + 8'(2 * gi))) begin
          alarm_time[gi*16 +: 16] <= reg_wdata;
        end
      end
    end
  endgenerate

  // Compare only while armed; software must disarm before editing words.
  assign alarm_match = ctrl.compare_enable && (local_time == alarm_time);

  // The mask bit is plain storage; the enable is also cleared by a match.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl.irq_mask <= 1'b0;
    end else if (wr_control) begin
      ctrl.irq_mask <= reg_wdata[ptp_time_pkg::CTRL_IRQ_MASK_BIT];
    end
  end

  // A match disarms even over a same-cycle write, so one match fires once.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl.compare_enable <= 1'b0;
    end else if (alarm_match) begin
      ctrl.compare_enable <= 1'b0;
    end else if (wr_control) begin
      ctrl.compare_enable <= reg_wdata[ptp_time_pkg::CTRL_COMPARE_EN_BIT];
    end
  end

  // ****************************************************************
  // Event status and interrupt
  // ****************************************************************
  // Set wins over a write-one clear so a match is never lost.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      alarm_one_pending <= 1'b0;
    end else if (alarm_match) begin
      alarm_one_pending <= 1'b1;
    end else if (wr_event && reg_wdata[ptp_time_pkg::EVENT_PENDING_BIT]) begin
      alarm_one_pending <= 1'b0;
    end
  end

  // Level interrupt while pending and unmasked.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      alarm_irq <= 1'b0;
    end else begin
      alarm_irq <= alarm_one_pending & ctrl.irq_mask;
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  logic [15:0] next_rdata;

  // Held halves answer upper reads even without a prior low read.
  always_comb begin
    next_rdata = 16'h0000;
    case (reg_addr)
      ptp_time_pkg::OFS_CONTROL: begin
        next_rdata[ptp_time_pkg::CTRL_IRQ_MASK_BIT] = ctrl.irq_mask;
        next_rdata[ptp_time_pkg::CTRL_COMPARE_EN_BIT] = ctrl.compare_enable;
      end
      ptp_time_pkg::OFS_EVENT: begin
        next_rdata[ptp_time_pkg::EVENT_PENDING_BIT] = alarm_one_pending;
      end
      ptp_time_pkg::OFS_ADDEND_LO: next_rdata = addend[15:0];
      ptp_time_pkg::OFS_ADDEND_HI: next_rdata = addend[31:16];
      ptp_time_pkg::OFS_FRAC_ACCUMULATOR_LOW: next_rdata = accum[15:0];
      ptp_time_pkg::OFS_FRAC_ACCUMULATOR_HIGH: next_rdata = accum_hold;
      ptp_time_pkg::OFS_TIME_W0: next_rdata = local_time[15:0];
      ptp_time_pkg::OFS_TIME_W1: next_rdata = time_hold[15:0];
      ptp_time_pkg::OFS_TIME_W2: next_rdata = time_hold[31:16];
      ptp_time_pkg::OFS_TIME_W3: next_rdata = time_hold[47:32];
      ptp_time_pkg::OFS_ALARM_W0: next_rdata = alarm_time[15:0];
      ptp_time_pkg::OFS_ALARM_W1: next_rdata = alarm_time[31:16];
      ptp_time_pkg::OFS_ALARM_W2: next_rdata = alarm_time[47:32];
      ptp_time_pkg::OFS_ALARM_W3: next_rdata = alarm_time[63:48];
      default: next_rdata = 16'h0000;
    endcase
  end

  // Data stand only in the cycle after the read strobe, zero otherwise.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule // ptp_system_time_counter

`default_nettype wire

//--- sim/host_fw_model.sv
// Host firmware model that drives the register port one access at a time.
`timescale 1ns/1ps
`default_nettype none

module host_fw_model (
  input wire logic clock,
  input wire logic [15:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  // The port starts idle so nothing is taken during reset.
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Released lines show the inverse so stale values cannot pass.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata;
  endtask
  // Two reads with no gap, so a snapshot is taken and used in back-to-back cycles.
  task automatic rd2(input logic [7:0] a, input logic [7:0] b,
                     output logic [15:0] da, output logic [15:0] db);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_addr <= b;
    #1 da = reg_rdata;
    @(posedge clock);
    reg_rd <= 1'b0;
    reg_addr <= ~b;
    #1 db = reg_rdata;
  endtask
  // Low half first, so the high write commits both halves together.
  task automatic wr_pair(input logic [7:0] a, input logic [31:0] v);
    wr(a, v[15:0]);
    wr(a + 8'h02, v[31:16]);
  endtask
  // Lower three words are staged before the top word commits.
  task automatic wr_time(input logic [63:0] v);
    for (int i = 0; i < 4; i++) wr(8'h0c + 8'(2 * i), v[16 * i +: 16]);
  endtask
  // Compare stays off meanwhile, so a half-written alarm cannot match.
  task automatic wr_alarm(input logic [63:0] v);
    wr(8'h00, 16'h0000);
    for (int i = 0; i < 4; i++) wr(8'h14 + 8'(2 * i), v[16 * i +: 16]);
  endtask
endmodule // host_fw_model

`default_nettype wire

//--- sim/ptp_system_time_counter_sva.sv
// Checker for time advance, register snapshots and the alarm interrupt.
`timescale 1ns/1ps
`default_nettype none

module ptp_system_time_counter_sva (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic alarm_irq,
  input wire logic [63:0] local_time,
  input wire logic time_tick
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic addend_set;
  logic t_wr;
  // A top time word write overrides any tick in the same cycle.
  assign t_wr = reg_wr && reg_addr == 8'h0c + 8'h06;
  // Remembers an addend commit; before it time must stand still.
  always_ff @(posedge clock) begin
    if (sys_rst) addend_set <= 1'b0;
    else if (reg_wr && reg_addr == 8'h06) addend_set <= 1'b1;
  end
  sequence s_lo_read;
    reg_rd && reg_addr == 8'h0c;
  endsequence
  sequence s_w1_read;
    reg_rd && reg_addr == 8'h0e;
  endsequence
  property p_tick_adv;
    time_tick && !t_wr |=> local_time == $past(local_time) + 64'h1;
  endproperty
  a_tick_adv: assert property (p_tick_adv)
    else $error("time did not advance after a tick");
  property p_hold;
    !time_tick && !t_wr |=> $stable(local_time);
  endproperty
  a_hold: assert property (p_hold)
    else $error("time moved without a tick");
  property p_time_load;
    t_wr |=> local_time[63:48] == $past(reg_wdata);
  endproperty
  a_time_load: assert property (p_time_load)
    else $error("top time word not loaded");
  property p_lo_read;
    s_lo_read |=> reg_rdata == 16'($past(local_time));
  endproperty
  a_lo_read: assert property (p_lo_read)
    else $error("time word 0 read wrong");
  property p_latch;
    s_lo_read ##1 s_w1_read |=> reg_rdata == 16'($past(local_time, 2) >> 16);
  endproperty
  a_latch: assert property (p_latch)
    else $error("time word 1 not from snapshot");
  property p_accum_load;
    reg_wr && reg_addr == 8'h0a |=> !time_tick;
  endproperty
  a_accum_load: assert property (p_accum_load)
    else $error("tick after accumulator load");
  property p_still;
    !addend_set |-> !time_tick;
  endproperty
  a_still: assert property (p_still)
    else $error("tick with reset addend");
  property p_mask_off;
    reg_wr && reg_addr == 8'h00 && !reg_wdata[0] |-> ##2 !alarm_irq;
  endproperty
  a_mask_off: assert property (p_mask_off)
    else $error("interrupt with mask clear");
  property p_irq_hold;
    alarm_irq && !reg_wr && !$past(reg_wr) |=> alarm_irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("interrupt dropped without clear");
endmodule // ptp_system_time_counter_sva

`default_nettype wire

//--- sim/ptp_system_time_counter_tb_top.sv
// Self-checking bench for the system time counter.
`timescale 1ns/1ps
`default_nettype none

module ptp_system_time_counter_tb_top;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, alarm_irq, time_tick;
  logic [63:0] local_time, v, w, n;
  logic [15:0] d1, d2;
  int num_errors = 0;
  int total_checks = 0;
  integer seed = 32'h14b4;
  always #12.5 clock = ~clock;
  host_fw_model u_host_fw_model (.clock(clock), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
  ptp_system_time_counter u_ptp_system_time_counter (.clock(clock), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .alarm_irq(alarm_irq), .local_time(local_time),
    .time_tick(time_tick));
  function automatic logic [15:0] word(input logic [63:0] x, input int i);
    return x[16 * i +: 16];
  endfunction
  // Wraps seen over c cycles with the accumulator starting from zero.
  function automatic logic [63:0] exp_ticks(input int c, input logic [31:0] a);
    return (64'(c) * 64'(a)) >> 32;
  endfunction
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    u_host_fw_model.rd(a, d);
    check($sformatf("reg %h", a), d, exp);
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Main sequence; the addend stays zero until the tick test so time is static.
  initial begin
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    u_host_fw_model.wr(8'h1c, 16'hffff);
    for (int a = 0; a <= 8'h1c; a += 2) rchk(8'(a), 16'h0000);
    $display("test reset values done");
    v = {$random(seed), $random(seed)};
    for (int i = 3; i >= 0; i--) u_host_fw_model.wr(8'h14 + 8'(2 * i), word(v, i));
    for (int i = 0; i < 4; i++) rchk(8'h14 + 8'(2 * i), word(v, i));
    $display("test alarm words done");
    v = 64'($random(seed));
    w = 64'($random(seed));
    u_host_fw_model.wr_pair(8'h08, v[31:0]);
    rchk(8'h08, v[15:0]);
    u_host_fw_model.wr_pair(8'h08, w[31:0]);
    rchk(8'h0a, v[31:16]);
    rchk(8'h08, w[15:0]);
    rchk(8'h0a, w[31:16]);
    $display("test accumulator done");
    v = {$random(seed), $random(seed)};
    u_host_fw_model.wr_time(v);
    #1 check("local_time", local_time, v);
    u_host_fw_model.rd2(8'h0c, 8'h0e, d1, d2);
    check("time word0", d1, word(v, 0));
    check("time word1", d2, word(v, 1));
    u_host_fw_model.wr(8'h0c, ~word(v, 0));
    #1 check("local_time", local_time, v);
    rchk(8'h0c, word(v, 0));
    u_host_fw_model.wr_time(~v);
    for (int i = 1; i < 4; i++) rchk(8'h0c + 8'(2 * i), word(v, i));
    $display("test time load done");
    u_host_fw_model.wr_pair(8'h08, 32'h0);
    u_host_fw_model.wr(8'h04, 16'h1234);
    rchk(8'h04, 16'h0000);
    u_host_fw_model.wr_pair(8'h04, 32'h8000_0000);
    rchk(8'h06, 16'h8000);
    n = 0;
    repeat (40) begin
      @(posedge clock);
      #1 n += time_tick;
    end
    check("ticks", n, exp_ticks(40, 32'h8000_0000));
    $display("test ticks done");
    for (int m = 1; m >= 0; m--) begin
      u_host_fw_model.wr_time(64'h0);
      u_host_fw_model.wr_alarm(64'h20);
      u_host_fw_model.wr(8'h00, 16'h0010 | 16'(m));
      for (n = 0; n < 300 && local_time < 64'h24; n++) @(posedge clock);
      if (n == 300) begin
        num_errors++;
        close_out();
      end
      rchk(8'h00, 16'(m));
      rchk(8'h02, 16'h0001);
      rchk(8'h02, 16'h0001);
      check("alarm_irq", alarm_irq, 64'(m));
      u_host_fw_model.wr(8'h02, 16'h0001);
      rchk(8'h02, 16'h0000);
      check("alarm_irq", alarm_irq, 64'h0);
    end
    $display("test alarm done");
    close_out();
  end
endmodule // ptp_system_time_counter_tb_top

bind ptp_system_time_counter ptp_system_time_counter_sva u_ptp_system_time_counter_sva (
  .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .alarm_irq(alarm_irq),
  .local_time(local_time), .time_tick(time_tick));

`default_nettype wire
